//--- rtl/ubd_pkg.sv
// ubd_pkg: offsets, field positions, reset values and types of the bridge control block
// assumes a 32-bit ahb slave port and a single system clock
package ubd_pkg;
  // register byte offsets inside the bridge window
  localparam logic [7:0] UBD_OFS_MASTER_SET = 8'h10;
  localparam logic [7:0] UBD_OFS_INT_REQ = 8'h14;
  localparam logic [7:0] UBD_OFS_INT_VAL = 8'h18;
  localparam logic [7:0] UBD_OFS_CORE_REQ = 8'h1C;
  localparam logic [7:0] UBD_OFS_CORE_VAL = 8'h20;
  // engine control bit positions in the master setting register
  localparam int UBD_BIT_RD_RESET = 6;
  localparam int UBD_BIT_RD_ABORT = 5;
  localparam int UBD_BIT_RD_ENABLE = 4;
  localparam int UBD_BIT_WR_RESET = 2;
  localparam int UBD_BIT_WR_ABORT = 1;
  localparam int UBD_BIT_WR_ENABLE = 0;
  // indirect request register layout
  localparam int UBD_BIT_REQ = 31;
  localparam int UBD_BIT_CLR = 30;
  localparam int UBD_ADR_LSB = 2;
  localparam int UBD_INT_ADR_W = 6;
  localparam int UBD_CORE_ADR_W = 8;
  localparam int UBD_CORE_DATA_W = 16;
  // reset values
  localparam logic [31:0] UBD_RST_INT_VAL = 32'h00000000;
  localparam logic [15:0] UBD_RST_CORE_VAL = 16'h0000;
  localparam logic [5:0] UBD_RST_INT_ADR = 6'h00;
  localparam logic [7:0] UBD_RST_CORE_ADR = 8'h00;
  // legal internal read targets (byte addresses)
  localparam logic [7:0] UBD_SEL_WR_CUR_ADDR = 8'h48;
  localparam logic [7:0] UBD_SEL_RD_CUR_ADDR = 8'h58;
  localparam logic [7:0] UBD_SEL_TIMEOUT_CNT = 8'h88;
  // control bundle toward one transfer engine
  typedef struct packed {
    logic reset;
    logic abort;
    logic enable;
  } ubd_eng_ctrl_s;
  // bus response sequencer
  typedef enum logic [1:0] {
    UBD_BUS_OKAY,
    UBD_BUS_ERR1,
    UBD_BUS_ERR2
  } ubd_bus_e;
endpackage

//--- rtl/ubd_ind_chan.sv
// ubd_ind_chan: one indirect register access channel with request, clear and value holder
// assumes ack arrives as a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module ubd_ind_chan
  import ubd_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 6,
  parameter logic [DATA_W-1:0] VAL_RST = '0,
  parameter logic [ADDR_W-1:0] ADR_RST = '0
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // software side
  input wire logic start,
  input wire logic clear,
  input wire logic addr_we,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic ext_busy,
  // target side
  input wire logic ack,
  input wire logic [DATA_W-1:0] ack_data,
  // state
  output logic req_q,
  output logic clr_q,
  output logic [ADDR_W-1:0] addr_q,
  output logic [DATA_W-1:0] value_q,
  output logic done_q,
  output logic abort_q
);
  if (DATA_W < 1 || DATA_W > 32 || ADDR_W < 1 || ADDR_W > 8)
  begin : g_chk
    $error("ubd_ind_chan: unsupported width");
  end

  logic req_d; // request and busy
  logic clr_d; // forced clearing in progress
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] value_d;
  logic done_d; // completion pulse
  logic abort_d; // abort pulse toward target

  // next state: clear beats start and ack, one request at a time
  always_comb
  begin
    req_d = req_q;
    clr_d = 1'b0; // forced clearing finishes in one cycle
    addr_d = addr_q;
    value_d = value_q;
    done_d = 1'b0;
    abort_d = 1'b0;
    if (addr_we && !req_q)
    begin
      addr_d = addr_in; // address held stable while busy
    end
    if (clear)
    begin
      req_d = 1'b0;
      clr_d = 1'b1;
      abort_d = req_q | ext_busy;
    end
    else if (req_q && ack)
    begin
      value_d = ack_data;
      req_d = 1'b0;
      done_d = 1'b1;
    end
    else if (start && !req_q && !ext_busy)
    begin
      req_d = 1'b1;
    end
  end

  // register stage
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      req_q <= 1'b0;
      clr_q <= 1'b0;
      addr_q <= ADR_RST;
      value_q <= VAL_RST;
      done_q <= 1'b0;
      abort_q <= 1'b0;
    end
    else
    begin
      req_q <= req_d;
      clr_q <= clr_d;
      addr_q <= addr_d;
      value_q <= value_d;
      done_q <= done_d;
      abort_q <= abort_d;
    end
  end
endmodule
`default_nettype wire

//--- rtl/ubd_ctrl.sv
// ubd_ctrl: transfer engine control bits and indirect read channels of the usb to ahb bridge
// assumes ahb-lite, 32-bit word accesses, all neighbours on sys_clk
`timescale 1ns/1ps
`default_nettype none
// Contract
// - read reset reinitialises read engine, self clears
// - read abort stops transfer, clears enable
// - read enable cleared at end, zero ignored
// - write reset reinitialises write engine, self clears
// - write abort stops transfer, clears enable
// - write enable cleared at end, zero ignored
// - select field picks one of three targets; the code passes on any six-bit select unchecked
// - internal read stores value, clears, flags done
// - internal clear forces request low, self clears
// - suspended access to request register errors
// - core read stores value, clears, flags done
// - request bit shows busy during core write
// - core clear stops access, self clears
// - core result in low sixteen bits
module ubd_ctrl
  import ubd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // ahb slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // power state
  input wire logic phy_suspend,
  // transfer engines
  output ubd_eng_ctrl_s rd_eng_ctrl,
  input wire logic rd_eng_done,
  output ubd_eng_ctrl_s wr_eng_ctrl,
  input wire logic wr_eng_done,
  // internal register read channel
  output logic int_rd_req,
  output logic [7:0] int_rd_addr,
  input wire logic int_rd_ack,
  input wire logic [31:0] int_rd_data,
  // core register channel
  output logic core_rd_req,
  output logic [7:0] core_rd_addr,
  input wire logic core_rd_ack,
  input wire logic [15:0] core_rd_data,
  input wire logic core_wr_active,
  output logic core_abort,
  // completion events for the interrupt status register
  output logic int_rd_done,
  output logic core_rd_done
);
  ubd_bus_e bus_q, bus_d; // response sequencer
  logic dp_wr_q, dp_wr_d; // write data phase pending
  logic [7:0] dp_addr_q, dp_addr_d; // data phase offset
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q, hreadyout_d;
  logic hresp_q, hresp_d;
  ubd_eng_ctrl_s rd_q, rd_d, wr_q, wr_d; // engine control bits
  logic addr_ph; // valid address phase this cycle
  logic [7:0] ofs; // word-aligned byte offset of address phase
  logic wr_ms, wr_ir, wr_cr; // write data phase hits
  logic ir_req, ir_clr, cr_req, cr_clr;
  logic [5:0] ir_adr;
  logic [7:0] cr_adr;
  logic [31:0] ir_val;
  logic [15:0] cr_val;

  // pulls one bit of the write data, named once
  function automatic logic wbit(input logic [31:0] d, input int pos);
    wbit = d[pos];
  endfunction

  // engine bit update shared by both directions
  function automatic ubd_eng_ctrl_s eng_next(input ubd_eng_ctrl_s cur, input logic we,
    input logic [31:0] d, input int rpos, input int apos, input int epos, input logic done);
    ubd_eng_ctrl_s n;
    n = cur;
    n.reset = 1'b0; // reset pulse clears itself after one cycle
    n.abort = 1'b0;
    if (done)
    begin
      n.enable = 1'b0; // end of transfer
    end
    if (we && d[epos] && !cur.enable)
    begin
      n.enable = 1'b1; // writing zero never stops a transfer
    end
    if (we && d[apos])
    begin
      n.abort = 1'b1;
      n.enable = 1'b0; // abort wins over a set in the same write
    end
    if (we && d[rpos])
    begin
      n.reset = 1'b1;
      n.enable = 1'b0;
    end
    eng_next = n;
  endfunction

  assign addr_ph = hsel && hready && htrans[1];
  assign ofs = {haddr[7:2], 2'b00};
  assign wr_ms = dp_wr_q && (dp_addr_q == UBD_OFS_MASTER_SET);
  assign wr_ir = dp_wr_q && (dp_addr_q == UBD_OFS_INT_REQ);
  assign wr_cr = dp_wr_q && (dp_addr_q == UBD_OFS_CORE_REQ);

  // bus sequencer and read mux; reads sample state at the address phase
  always_comb
  begin
    bus_d = UBD_BUS_OKAY;
    dp_wr_d = 1'b0;
    dp_addr_d = dp_addr_q;
    hrdata_d = 32'h00000000; // unused bits read zero
    hreadyout_d = 1'b1;
    hresp_d = 1'b0;
    case (bus_q)
      UBD_BUS_ERR1:
      begin
        bus_d = UBD_BUS_ERR2; // second cycle of error response
        hresp_d = 1'b1;
      end
      // second error cycle has hready high, so an address phase then is taken as usual
      default:
      begin
        if (addr_ph && phy_suspend && ofs == UBD_OFS_INT_REQ)
        begin
          bus_d = UBD_BUS_ERR1;
          hreadyout_d = 1'b0;
          hresp_d = 1'b1;
        end
        else if (addr_ph && hwrite)
        begin
          dp_wr_d = 1'b1;
          dp_addr_d = ofs;
        end
        else if (addr_ph)
        begin
          if (ofs == UBD_OFS_MASTER_SET)
          begin
            hrdata_d[UBD_BIT_RD_RESET] = rd_q.reset;
            hrdata_d[UBD_BIT_RD_ENABLE] = rd_q.enable;
            hrdata_d[UBD_BIT_WR_RESET] = wr_q.reset;
            hrdata_d[UBD_BIT_WR_ENABLE] = wr_q.enable;
          end
          else if (ofs == UBD_OFS_INT_REQ)
          begin
            hrdata_d[UBD_BIT_REQ] = ir_req;
            hrdata_d[UBD_BIT_CLR] = ir_clr;
            hrdata_d[7:2] = ir_adr;
          end
          else if (ofs == UBD_OFS_INT_VAL)
          begin
            hrdata_d = ir_val;
          end
          else if (ofs == UBD_OFS_CORE_REQ)
          begin
            hrdata_d[UBD_BIT_REQ] = cr_req | core_wr_active;
            hrdata_d[UBD_BIT_CLR] = cr_clr;
            hrdata_d[9:2] = cr_adr;
          end
          else if (ofs == UBD_OFS_CORE_VAL)
          begin
            hrdata_d[15:0] = cr_val;
          end
        end
      end
    endcase
  end

  // bus stage registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      bus_q <= UBD_BUS_OKAY;
      dp_wr_q <= 1'b0;
      dp_addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
    else
    begin
      bus_q <= bus_d;
      dp_wr_q <= dp_wr_d;
      dp_addr_q <= dp_addr_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= hreadyout_d;
      hresp_q <= hresp_d;
    end
  end

  // engine control bits, written at the data phase
  always_comb
  begin
    rd_d = eng_next(rd_q, wr_ms, hwdata, UBD_BIT_RD_RESET, UBD_BIT_RD_ABORT,
      UBD_BIT_RD_ENABLE, rd_eng_done);
    wr_d = eng_next(wr_q, wr_ms, hwdata, UBD_BIT_WR_RESET, UBD_BIT_WR_ABORT,
      UBD_BIT_WR_ENABLE, wr_eng_done);
  end

  // engine control registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rd_q <= '0;
      wr_q <= '0;
    end
    else
    begin
      rd_q <= rd_d;
      wr_q <= wr_d;
    end
  end

  // internal register read channel; targets beyond the three are software's concern
  ubd_ind_chan #(
    .DATA_W(32),
    .ADDR_W(UBD_INT_ADR_W),
    .VAL_RST(UBD_RST_INT_VAL),
    .ADR_RST(UBD_RST_INT_ADR)
  ) u_int_chan (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(wr_ir && wbit(hwdata, UBD_BIT_REQ)),
    .clear(wr_ir && wbit(hwdata, UBD_BIT_CLR)),
    .addr_we(wr_ir),
    .addr_in(hwdata[7:2]),
    .ext_busy(1'b0),
    .ack(int_rd_ack),
    .ack_data(int_rd_data),
    .req_q(ir_req),
    .clr_q(ir_clr),
    .addr_q(ir_adr),
    .value_q(ir_val),
    .done_q(int_rd_done),
    .abort_q()
  );

  // core register channel; core writes elsewhere block new requests
  ubd_ind_chan #(
    .DATA_W(UBD_CORE_DATA_W),
    .ADDR_W(UBD_CORE_ADR_W),
    .VAL_RST(UBD_RST_CORE_VAL),
    .ADR_RST(UBD_RST_CORE_ADR)
  ) u_core_chan (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(wr_cr && wbit(hwdata, UBD_BIT_REQ)),
    .clear(wr_cr && wbit(hwdata, UBD_BIT_CLR)),
    .addr_we(wr_cr),
    .addr_in(hwdata[9:2]),
    .ext_busy(core_wr_active),
    .ack(core_rd_ack),
    .ack_data(core_rd_data),
    .req_q(cr_req),
    .clr_q(cr_clr),
    .addr_q(cr_adr),
    .value_q(cr_val),
    .done_q(core_rd_done),
    .abort_q(core_abort)
  );

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign rd_eng_ctrl = rd_q;
  assign wr_eng_ctrl = wr_q;
  assign int_rd_req = ir_req;
  assign int_rd_addr = {ir_adr, 2'b00};
  assign core_rd_req = cr_req;
  assign core_rd_addr = cr_adr;
endmodule
`default_nettype wire

//--- sim/ubd_ctrl_monitor.sv
// ubd_ctrl_monitor: port checks of ubd_ctrl
// assumes one clock domain, bound onto ubd_ctrl below
`timescale 1ns/1ps
`default_nettype none
module ubd_ctrl_monitor
  import ubd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // engines
  input wire ubd_eng_ctrl_s rd_eng_ctrl,
  input wire ubd_eng_ctrl_s wr_eng_ctrl,
  input wire logic rd_eng_done,
  input wire logic wr_eng_done,
  // indirect channels
  input wire logic int_rd_req,
  input wire logic [7:0] int_rd_addr,
  input wire logic int_rd_ack,
  input wire logic core_rd_req,
  input wire logic core_rd_ack,
  input wire logic int_rd_done,
  input wire logic core_rd_done,
  input wire logic core_abort
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // reset bits pulse once and leave the engine disabled
  chk_rd_reset_pulse:
    assert property ($rose(rd_eng_ctrl.reset) |=> !rd_eng_ctrl.reset && !rd_eng_ctrl.enable)
    else $error("read reset not a clean pulse");
  chk_wr_reset_pulse:
    assert property ($rose(wr_eng_ctrl.reset) |=> !wr_eng_ctrl.reset && !wr_eng_ctrl.enable)
    else $error("write reset not a clean pulse");
  // abort or done leaves enable low
  chk_rd_abort_clr:
    assert property (rd_eng_ctrl.abort |=> !rd_eng_ctrl.enable)
    else $error("read abort kept enable");
  chk_wr_abort_clr:
    assert property (wr_eng_ctrl.abort |=> !wr_eng_ctrl.enable)
    else $error("write abort kept enable");
  chk_eng_done_clr:
    assert property ((rd_eng_done |=> !rd_eng_ctrl.enable) and
      (wr_eng_done |=> !wr_eng_ctrl.enable))
    else $error("enable survived done");
  // an acked request falls with its done pulse
  chk_int_ack_done:
    assert property (int_rd_req && int_rd_ack |=> !int_rd_req && int_rd_done)
    else $error("internal read did not complete");
  chk_core_ack_done:
    assert property (core_rd_req && core_rd_ack |=> !core_rd_req && core_rd_done)
    else $error("core read did not complete");
  // forced clear drops the request with no completion; select holds while a request is pending
  chk_core_abort_drop:
    assert property (core_abort |-> !core_rd_req && !core_rd_done)
    else $error("core abort left request or done");
  chk_int_addr_hold:
    assert property (int_rd_req |=> $stable(int_rd_addr))
    else $error("select moved while pending");
  // error answer spans two cycles
  chk_err_two_cycle:
    assert property (!hreadyout |-> hresp ##1 (hresp && hreadyout))
    else $error("bad error response");
  cov_int_read: cover property (int_rd_done);
  cov_core_read: cover property (core_rd_done);
  cov_bus_error: cover property (!hreadyout ##1 hresp);
  cov_core_abort: cover property (core_abort);
  cov_eng_reset: cover property (rd_eng_ctrl.reset);
endmodule
bind ubd_ctrl ubd_ctrl_monitor u_ubd_ctrl_monitor (.sys_clk, .rst, .hreadyout, .hresp,
  .rd_eng_ctrl, .wr_eng_ctrl, .rd_eng_done, .wr_eng_done, .int_rd_req, .int_rd_addr,
  .int_rd_ack, .core_rd_req, .core_rd_ack, .int_rd_done, .core_rd_done, .core_abort);
`default_nettype wire

//--- sim/ubd_far_model.sv
// ubd_far_model: targets behind both indirect channels
// assumes requests stay high until acked or cleared
`timescale 1ns/1ps
`default_nettype none
module ubd_far_model
(
  // clock, reset, answer delay
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] dly,
  // internal register target
  input wire logic int_rd_req,
  input wire logic [7:0] int_rd_addr,
  output logic int_rd_ack,
  output logic [31:0] int_rd_data,
  // core register target
  input wire logic core_rd_req,
  input wire logic [7:0] core_rd_addr,
  output logic core_rd_ack,
  output logic [15:0] core_rd_data
);
  logic [3:0] ic, cc; // wait counters
  // one ack after dly cycles; data toggles while not valid, so stale values never match
  always @(posedge sys_clk)
  begin
    ic <= int_rd_req && !rst ? ic + 4'h1 : 4'h0;
    cc <= core_rd_req && !rst ? cc + 4'h1 : 4'h0;
    int_rd_ack <= int_rd_req && !int_rd_ack && ic == dly && !rst;
    core_rd_ack <= core_rd_req && !core_rd_ack && cc == dly && !rst;
    int_rd_data <= ic == dly ? {24'hC3A5E1, int_rd_addr} : ~int_rd_data;
    core_rd_data <= cc == dly ? {8'h5A, core_rd_addr} : ~core_rd_data;
  end
endmodule
`default_nettype wire

//--- sim/tb_usb_bridge_dma_ctrl_indirect_read.sv
// tb_usb_bridge_dma_ctrl_indirect_read: self-checking bench of ubd_ctrl
// assumes ubd_far_model answers both indirect channels
`timescale 1ns/1ps
`default_nettype none
module tb_usb_bridge_dma_ctrl_indirect_read
  import ubd_pkg::*;
;
  localparam logic [32:0] MW = 33'h100000000; // response bit only
  logic sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp, phy_suspend, dp_q;
  logic rd_eng_done, wr_eng_done, int_rd_req, int_rd_ack, core_rd_req, core_rd_ack;
  logic core_wr_active, core_abort, int_rd_done, core_rd_done;
  logic [31:0] haddr, hwdata, hrdata, int_rd_data;
  logic [15:0] core_rd_data;
  logic [7:0] int_rd_addr, core_rd_addr, a;
  logic [3:0] dly;
  logic [1:0] htrans;
  ubd_eng_ctrl_s rd_eng_ctrl, wr_eng_ctrl;
  logic [32:0] exp_q[$], msk_q[$]; // expected answers, oldest first
  logic [7:0] sel_t[3] = '{8'h48, 8'h58, 8'h88}; // legal targets
  int fails, comparisons, s;
  int aborts; // core abort pulses seen
  assign hready = hreadyout; // bus waits on the slave
  ubd_ctrl u_ubd_ctrl (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .phy_suspend, .rd_eng_ctrl, .rd_eng_done, .wr_eng_ctrl,
    .wr_eng_done, .int_rd_req, .int_rd_addr, .int_rd_ack, .int_rd_data, .core_rd_req,
    .core_rd_addr, .core_rd_ack, .core_rd_data, .core_wr_active, .core_abort,
    .int_rd_done, .core_rd_done);
  ubd_far_model u_ubd_far_model (.sys_clk, .rst, .dly, .int_rd_req, .int_rd_addr,
    .int_rd_ack, .int_rd_data, .core_rd_req, .core_rd_addr, .core_rd_ack, .core_rd_data);
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    comparisons++;
    if (seen !== want)
    begin
      fails++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one ahb beat; its answer is noted for the watcher
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
    input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
  endtask
  // writes idle two cycles so a following read sees the update
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d, 33'h0, MW);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, ad, 32'h0, {1'b0, e}, {1'b1, m});
  endtask
  // bounded wait for a completion pulse
  task automatic wait_done(input logic c);
    int n;
    for (n = 0; n < 64 && (c ? core_rd_done : int_rd_done) !== 1'b1; n++)
      @(posedge sys_clk);
    check({32'h0, n < 64}, 33'h1);
  endtask
  // watcher: compares each data phase with the oldest note
  always @(posedge sys_clk)
  begin
    if (dp_q && exp_q.size() > 0)
      check({hresp, hrdata} & msk_q.pop_front(), exp_q.pop_front());
    dp_q <= hsel && htrans[1] && hready && !rst;
    if (core_abort === 1'b1)
      aborts++;
  end
  initial
  begin
    {rst, hsel, hwrite, phy_suspend, rd_eng_done, wr_eng_done, core_wr_active} = 7'h40;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    dly = 4'h0;
    void'($urandom(32'h3040e24c));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // reset values, unmapped offset last
    rd(8'h10, 32'h0, 32'h77);
    rd(8'h14, 32'h0, 32'hC00000FC);
    rd(8'h18, 32'h0, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0, 32'hC00003FC);
    rd(8'h20, 32'h0, 32'hFFFF);
    rd(8'h24, 32'h0, 32'hFFFFFFFF);
    // both engines: enable, ignored zero, done, abort, reset when stopped
    for (s = 0; s < 8; s += 4)
    begin
      wr(8'h10, 32'h1 << s);
      wr(8'h10, 32'h0);
      rd(8'h10, 32'h1 << s, 32'h77);
      if (s == 4) rd_eng_done <= 1'b1;
      else wr_eng_done <= 1'b1;
      @(posedge sys_clk);
      rd_eng_done <= 1'b0;
      wr_eng_done <= 1'b0;
      rd(8'h10, 32'h0, 32'h77);
      wr(8'h10, 32'h1 << s);
      wr(8'h10, 32'h2 << s);
      rd(8'h10, 32'h0, 32'h77);
      wr(8'h10, 32'h4 << s);
      rd(8'h10, 32'h0, 32'h77);
    end
    // every legal internal target, prompt answer
    dly <= 4'h2;
    for (s = 0; s < 3; s++)
    begin
      wr(8'h14, 32'h80000000 | sel_t[s]);
      wait_done(1'b0);
      rd(8'h18, 32'hC3A5E100 | sel_t[s], 32'hFFFFFFFF);
      rd(8'h14, sel_t[s], 32'hC00000FC);
    end
    // slow answer: second request ignored, then a forced clear
    dly <= 4'hC;
    a = sel_t[$urandom % 2];
    wr(8'h14, 32'h80000000 | a);
    wr(8'h14, 32'h80000000 | (a ^ 8'h10));
    rd(8'h14, 32'h80000000 | a, 32'hC00000FC);
    wait_done(1'b0);
    rd(8'h18, 32'hC3A5E100 | a, 32'hFFFFFFFF);
    wr(8'h14, 32'h80000000 | a);
    wr(8'h14, 32'h40000000 | a);
    rd(8'h14, a, 32'h800000FC);
    repeat (20) @(posedge sys_clk);
    rd(8'h14, a, 32'hC00000FC);
    // core read at a random address
    a = 8'($urandom);
    wr(8'h1C, {22'h200000, a, 2'h0});
    wait_done(1'b1);
    rd(8'h20, {16'h0, 8'h5A, a}, 32'hFFFF);
    // busy during a core write refuses a request
    core_wr_active <= 1'b1;
    wr(8'h1C, 32'h80000000);
    rd(8'h1C, 32'h80000000, 32'hC0000000);
    core_wr_active <= 1'b0;
    rd(8'h1C, 32'h0, 32'hC0000000);
    wr(8'h1C, {22'h200000, a, 2'h0});
    wr(8'h1C, 32'h40000000);
    rd(8'h1C, 32'h0, 32'h80000000);
    check({1'b0, aborts}, 33'h1);
    // suspended phy: both access kinds refused
    phy_suspend <= 1'b1;
    bus(1'b0, 8'h14, 32'h0, MW, MW);
    repeat (2) @(posedge sys_clk);
    bus(1'b1, 8'h14, 32'h80000048, MW, MW);
    repeat (2) @(posedge sys_clk);
    phy_suspend <= 1'b0;
    rd(8'h14, 32'h0, 32'h80000000);
    repeat (2) @(posedge sys_clk);
    tally_and_finish();
  end
  // hang guard, far above the expected run
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
